// File: common/tdpa_pkg.sv
/*
  Shared constants for the two-wire dual pointer access block: target
  identifiers, pointer widths, register range, reset values and buffer sizes.
  Assumes nothing of its surroundings; it holds definitions only.
*/
`default_nettype none

package tdpa_pkg;

  // Number of bits in every byte on the link.
  localparam int unsigned TDPA_BYTE_BITS = 8;

  // Identifier nibble (slave address bits 7 to 4) of the memory target.
  localparam logic [3:0] TDPA_ID_MEM = 4'ha;

  // Identifier nibble of the clock/companion register target.
  localparam logic [3:0] TDPA_ID_REG = 4'hd;

  // Highest legal register address; anything above is refused.
  localparam logic [7:0] TDPA_REG_MAX = 8'h18;

  // Lowest register address, used when the pointer wraps.
  localparam logic [7:0] TDPA_REG_MIN = 8'h00;

  // Default memory address width (largest density, 15 bits).
  localparam int unsigned TDPA_MEM_AW = 15;

  // Full width of the two-byte memory address on the link.
  localparam int unsigned TDPA_LINK_AW = 16;

  // Pointer values after reset and after supply loss.
  localparam logic [15:0] TDPA_MEM_PTR_RST = 16'h0000;
  localparam logic [7:0]  TDPA_REG_PTR_RST = 8'h00;

  // Depth of the write command buffer.
  localparam int unsigned TDPA_FIFO_DEPTH = 16;

  // Byte index values within one transaction.
  localparam logic [1:0] TDPA_IDX_SLAVE = 2'h0;
  localparam logic [1:0] TDPA_IDX_ADR1  = 2'h1;
  localparam logic [1:0] TDPA_IDX_ADR2  = 2'h2;
  localparam logic [1:0] TDPA_IDX_DATA  = 2'h3;

  // Target selected by the slave address.
  typedef enum logic {
    TDPA_TGT_MEM,
    TDPA_TGT_REG
  } tdpa_tgt_type;

endpackage

`default_nettype wire

// File: logic/tdpa_fifo.sv
/*
  Synchronous FIFO used for write commands on their way to storage.
  Width and depth are parameters; the output word sits in a register.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module tdpa_fifo
  import tdpa_pkg::*;
#(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = TDPA_FIFO_DEPTH
)
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];  // Storage array.
  logic [PW-1:0]    wr_ptr_r;       // Next slot to write.
  logic [PW-1:0]    rd_ptr_r;       // Next slot to read.
  logic [PW:0]      count_r;        // Words held in the array.
  logic             push;           // Word accepted this cycle.
  logic             pop;            // Word moved to the output register.

  // Full counts the output word too.
  assign in_ready = (count_r + (PW+1)'(out_valid) != (PW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  // The output register refills when it is empty or being drained.
  assign pop      = (count_r != '0) && (!out_valid || out_ready);

  // Array write; no reset needed for data.
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Output register stage, so the consumer sees flip-flop outputs.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data  <= mem_r[rd_ptr_r];
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: logic/tdpa_slave.sv
/*
  Two-wire slave access logic with a memory pointer and a register pointer.
  The link pins are sampled by core_clk; SCL edges are found by oversampling.
  Assumes a storage side that answers a read request within a few cycles and
  drains write commands through the buffer; SDA is open drain outside.
*/
// How it works
// RL1 - Memory write: address high byte, then low.
// RL2 - Unused upper memory address bits are ignored.
// RL3 - Memory pointer kept while supply stays good.
// RL4 - Pointer increments after each byte, before acknowledge.
// RL5 - Memory pointer wraps to zero; unlimited length.
// RL6 - Separate memory and register pointers.
// RL7 - Register target: one address byte, 00h-18h.
// RL8 - Register address above 18h: NACK, abort.
// RL9 - Read: send 8 bits, then sample master acknowledge.
// RL10 - Write: take 8 bits, then acknowledge.
// RL11 - All bytes most significant bit first.
// RL12 - Write commits at 8th bit, before acknowledge.
// RL13 - Slave address bit 0 low means write.
// RL14 - Bit 0 high: send data from pointer.
// RL15 - Master ends reads by NACK, Stop or Start.
// RL16 - Repeated Start after address load serves read.
// RL17 - Register pointer auto-increments like memory pointer.
// RL18 - First write bytes always load the address.
// RL19 - Master should zero register address bits 7-5.
// RL20 - Identifiers 1010b memory, 1101b register; register never touches memory.
// RL21 - Address bits 2-1 must match select pins.
// RL22 - Start anywhere aborts and awaits slave address.
// RL23 - Register pointer wraps from 18h to 00h.
`timescale 1ns/100ps
`default_nettype none

module tdpa_slave
  import tdpa_pkg::*;
#(
  parameter int unsigned MEM_AW = TDPA_MEM_AW
)
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_n,
  input  wire logic [1:0]              dev_sel,
  input  wire logic                    supply_ok,
  output logic                         rd_req,
  output logic                         rd_tgt,
  output logic      [TDPA_LINK_AW-1:0] rd_addr,
  input  wire logic                    rd_valid,
  input  wire logic [7:0]              rd_data,
  output logic                         wr_valid,
  input  wire logic                    wr_ready,
  output logic                         wr_tgt,
  output logic      [TDPA_LINK_AW-1:0] wr_addr,
  output logic      [7:0]              wr_data
);

  localparam int unsigned CW = 1 + TDPA_LINK_AW + 8;  // Command width.

  typedef enum logic [2:0] {
    TDPA_ST_IDLE,  // Not addressed; waits for a Start.
    TDPA_ST_RX,    // Receiving a byte from the master.
    TDPA_ST_ACK,   // Driving our acknowledge.
    TDPA_ST_TX,    // Sending a data byte.
    TDPA_ST_RACK   // Waiting for the master acknowledge.
  } tdpa_state_type;

  tdpa_state_type         state_r;      // Link state.
  logic [1:0]             scl_s_r;      // Two-stage SCL synchroniser.
  logic [1:0]             sda_s_r;      // Two-stage SDA synchroniser.
  logic [1:0]             sel_s0_r;     // Select pins, first stage.
  logic [1:0]             sel_s1_r;     // Select pins, second stage.
  logic [1:0]             sup_s_r;      // Supply-good synchroniser.
  logic                   scl_d_r;      // Previous synchronised SCL.
  logic                   sda_d_r;      // Previous synchronised SDA.
  logic [7:0]             sh_r;         // Shift register, MSB first.
  logic [3:0]             bit_cnt_r;    // Bits moved in current byte.
  logic [1:0]             idx_r;        // Byte position in transaction.
  logic                   tgt_r;        // 1 selects the register target.
  logic                   rw_r;         // 1 for a read transaction.
  logic                   ack_ok_r;     // Acknowledge decision for the byte.
  logic [15:0]            mem_ptr_r;    // Memory address latch.
  logic [7:0]             adr_hi_r;     // High address byte awaiting low.
  logic [7:0]             reg_ptr_r;    // Register address pointer.
  logic [7:0]             rd_buf_r;     // Prefetched read byte.
  logic                   push;         // Write command offered to buffer.
  logic                   buf_ready;    // Buffer can take a command.
  logic [CW-1:0]          push_word;    // Command word.
  logic [CW-1:0]          pop_word;     // Command word at the buffer output.
  logic                   scl_rise;     // SCL went high.
  logic                   scl_fall;     // SCL went low.
  logic                   start_det;    // SDA fell while SCL high.
  logic                   stop_det;     // SDA rose while SCL high.
  logic [7:0]             rx_byte;      // Byte complete at the 8th rise.
  logic                   byte_done;    // 8th bit of a received byte.

  // Masks a link address down to the implemented density.
  function automatic logic [15:0] mem_mask(input logic [15:0] a);
    mem_mask = a & ((16'h0001 << MEM_AW) - 16'h0001);
  endfunction

  // Next register address; wraps instead of entering the illegal range.
  function automatic logic [7:0] reg_next(input logic [7:0] p);
    reg_next = (p >= TDPA_REG_MAX) ? TDPA_REG_MIN : p + 8'h01;  // [RL23]
  endfunction

  // Synchronisers: the first stage feeds only the second stage.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      scl_s_r  <= 2'h3;
      sda_s_r  <= 2'h3;
      sel_s0_r <= 2'h0;
      sel_s1_r <= 2'h0;
      sup_s_r  <= 2'h0;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end
    else
    begin
      scl_s_r  <= {scl_s_r[0], scl_in};
      sda_s_r  <= {sda_s_r[0], sda_in};
      sel_s0_r <= dev_sel;
      sel_s1_r <= sel_s0_r;
      sup_s_r  <= {sup_s_r[0], supply_ok};
      scl_d_r  <= scl_s_r[1];
      sda_d_r  <= sda_s_r[1];
    end
  end

  // Edge and condition detection on the synchronised pins.
  assign scl_rise  = scl_s_r[1] && !scl_d_r;
  assign scl_fall  = !scl_s_r[1] && scl_d_r;
  assign start_det = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
  assign stop_det  = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];
  assign rx_byte   = {sh_r[6:0], sda_s_r[1]};  // [RL11]
  assign byte_done = (state_r == TDPA_ST_RX) && scl_rise && (bit_cnt_r == 4'h7);

  // A write data byte becomes a command at its 8th bit, if acknowledged.
  // The register target never reaches the memory side of the command.
  assign push = byte_done && !rw_r && (idx_r == TDPA_IDX_DATA) && buf_ready;  // [RL12]
  assign push_word = {tgt_r, tgt_r ? {8'h00, reg_ptr_r} : mem_ptr_r, rx_byte};  // [RL20]

  // Link state machine; Start and Stop take priority over bit traffic.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !sup_s_r[1])
    begin
      state_r   <= TDPA_ST_IDLE;
      bit_cnt_r <= 4'h0;
      idx_r     <= TDPA_IDX_SLAVE;
      sh_r      <= 8'h00;
    end
    else if (start_det)
    begin
      // Abort anything, including a pending write, and await an address.
      state_r   <= TDPA_ST_RX;  // [RL22] [RL16]
      bit_cnt_r <= 4'h0;
      idx_r     <= TDPA_IDX_SLAVE;
    end
    else if (stop_det)
    begin
      state_r <= TDPA_ST_IDLE;  // [RL15]
    end
    else
    begin
      case (state_r)
        TDPA_ST_RX:
        begin
          if (scl_rise)
          begin
            sh_r      <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 4'h1;  // [RL10]
          end
          else if (scl_fall && bit_cnt_r == 4'h8)
          begin
            // Refused bytes release SDA and drop off the bus.
            state_r <= ack_ok_r ? TDPA_ST_ACK : TDPA_ST_IDLE;  // [RL8]
          end
        end
        TDPA_ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_r <= 4'h0;
            if (idx_r != TDPA_IDX_DATA)
            begin
              // Register target needs only one address byte.
              idx_r <= (idx_r == TDPA_IDX_ADR1 && tgt_r) ? TDPA_IDX_DATA : idx_r + 2'h1;  // [RL7] [RL18]
            end
            if (rw_r)
            begin
              // Data goes out on the clock after the acknowledge.
              state_r <= TDPA_ST_TX;  // [RL14]
              sh_r    <= rd_buf_r;
              idx_r   <= TDPA_IDX_DATA;
            end
            else
            begin
              state_r <= TDPA_ST_RX;  // [RL13]
            end
          end
        end
        TDPA_ST_TX:
        begin
          if (scl_fall)
          begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            sh_r      <= {sh_r[6:0], 1'b0};  // [RL11]
            if (bit_cnt_r == 4'h7)
            begin
              state_r <= TDPA_ST_RACK;  // [RL9]
            end
          end
        end
        TDPA_ST_RACK:
        begin
          if (scl_rise)
          begin
            // A NACK ends the read; the master then sends Stop or Start.
            state_r <= sda_s_r[1] ? TDPA_ST_IDLE : TDPA_ST_RACK;  // [RL9] [RL15]
            bit_cnt_r <= 4'h9;
          end
          else if (scl_fall && bit_cnt_r == 4'h9)
          begin
            state_r   <= TDPA_ST_TX;
            bit_cnt_r <= 4'h0;
            sh_r      <= rd_buf_r;
          end
        end
        TDPA_ST_IDLE:
        begin
          bit_cnt_r <= 4'h0;
        end
        default:
        begin
          state_r <= TDPA_ST_IDLE;
        end
      endcase
    end
  end

  // Byte decisions taken at the 8th rising edge of each received byte.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ack_ok_r <= 1'b0;
      tgt_r    <= 1'b0;
      rw_r     <= 1'b0;
      adr_hi_r <= 8'h00;
    end
    else if (byte_done)
    begin
      case (idx_r)
        TDPA_IDX_SLAVE:
        begin
          // Identifier and select pins must both match.
          ack_ok_r <= (rx_byte[7:4] == TDPA_ID_MEM || rx_byte[7:4] == TDPA_ID_REG)
                      && (rx_byte[2:1] == sel_s1_r);  // [RL20] [RL21]
          tgt_r    <= (rx_byte[7:4] == TDPA_ID_REG);
          rw_r     <= rx_byte[0];  // [RL13] [RL14]
        end
        TDPA_IDX_ADR1:
        begin
          ack_ok_r <= !tgt_r || (rx_byte <= TDPA_REG_MAX);  // [RL7] [RL8]
          adr_hi_r <= rx_byte;  // [RL1]
        end
        TDPA_IDX_ADR2:
        begin
          ack_ok_r <= 1'b1;
        end
        default:
        begin
          // A full buffer cannot take the byte, so it is refused.
          ack_ok_r <= buf_ready;  // [RL12]
        end
      endcase
    end
  end

  // Memory pointer: loaded by the low address byte, stepped per byte.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !sup_s_r[1])
    begin
      // Contents are only guaranteed while the supply stays good.
      mem_ptr_r <= TDPA_MEM_PTR_RST;  // [RL3]
    end
    else if (!tgt_r)  // [RL6]
    begin
      if (byte_done && idx_r == TDPA_IDX_ADR2)
      begin
        mem_ptr_r <= mem_mask({adr_hi_r, rx_byte});  // [RL1] [RL2]
      end
      else if (push || (state_r == TDPA_ST_TX && scl_fall && bit_cnt_r == 4'h7))
      begin
        // Step before the acknowledge; wraps at the top of the array.
        mem_ptr_r <= mem_mask(mem_ptr_r + 16'h0001);  // [RL4] [RL5]
      end
    end
  end

  // Register pointer: single address byte, stepped per byte.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !sup_s_r[1])
    begin
      reg_ptr_r <= TDPA_REG_PTR_RST;
    end
    else if (tgt_r)  // [RL6]
    begin
      if (byte_done && idx_r == TDPA_IDX_ADR1 && rx_byte <= TDPA_REG_MAX)
      begin
        reg_ptr_r <= rx_byte;  // [RL7]
      end
      else if (push || (state_r == TDPA_ST_TX && scl_fall && bit_cnt_r == 4'h7))
      begin
        reg_ptr_r <= reg_next(reg_ptr_r);  // [RL17]
      end
    end
  end

  // Read prefetch: request the byte at the pointer once the pointer settles.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rd_req   <= 1'b0;
      rd_tgt   <= 1'b0;
      rd_addr  <= 16'h0000;
      rd_buf_r <= 8'h00;
    end
    else
    begin
      // Fetch after the slave address, or at the ack rise once the pointer stepped.
      rd_req  <= rw_r && ((scl_fall && state_r == TDPA_ST_RX && bit_cnt_r == 4'h8)
                 || (scl_rise && state_r == TDPA_ST_RACK));
      rd_tgt  <= tgt_r;
      rd_addr <= tgt_r ? {8'h00, reg_ptr_r} : mem_ptr_r;
      if (rd_valid)
      begin
        rd_buf_r <= rd_data;
      end
    end
  end

  // SDA driver: open drain, low enable means the pin is pulled low.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      sda_out  <= 1'b0;
      sda_oe_n <= !((state_r == TDPA_ST_ACK) || (state_r == TDPA_ST_TX && !sh_r[7]));  // [RL9] [RL10]
    end
  end

  tdpa_fifo #(
    .WIDTH (CW),
    .DEPTH (TDPA_FIFO_DEPTH)
  ) u_cmd_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (push_word),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (pop_word)
  );

  // Command fields; the buffer output already comes from registers.
  assign wr_tgt  = pop_word[CW-1];
  assign wr_addr = pop_word[CW-2:8];
  assign wr_data = pop_word[7:0];

endmodule

`default_nettype wire

// File: verification/tdpa_master_model.sv
/*
  Two-wire bus master model: drives SCL and pulls SDA low, bit by bit.
  Assumes a pull-up on SDA and a core_clk whose falling edge paces it.
*/
`timescale 1ns/100ps
`default_nettype none

module tdpa_master_model
(
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull_n
);
  // SCL stands high between frames; SDA is released.
  initial
  begin
    scl = 1'b1;
    pull_n = 1'b1;
  end

  // A quarter of the 64 ns bit time, 4 core clocks.
  task automatic qtr();
    repeat (4) @(negedge core_clk);
  endtask

  // One bit: SDA moves only while SCL is low, sampled mid high phase.
  task automatic bit_io(input logic b, output logic r);
    pull_n = b;
    qtr();
    scl = 1'b1;
    qtr();
    r = sda;
    qtr();
    scl = 1'b0;
    qtr();
  endtask

  // Start, also usable as a repeated Start.
  task automatic start_c();
    pull_n = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    pull_n = 1'b0;
    qtr();
    scl = 1'b0;
    qtr();
  endtask

  // Stop leaves SCL high, the idle state.
  task automatic stop_c();
    pull_n = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    pull_n = 1'b1;
    qtr();
  endtask

  // Byte out, most significant bit first, then the slave's answer.
  task automatic wr_byte(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, nack);
  endtask

  // Byte in; a NACK here and then a Stop ends the read.
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule

`default_nettype wire

// File: verification/tdpa_slave_sva.sv
/*
  Checker for the two-wire slave, watching only its ports.
  Assumes core_clk and a synchronous active-low rst_n; bound below.
*/
`timescale 1ns/100ps
`default_nettype none

module tdpa_slave_sva
  import tdpa_pkg::*;
#(
  parameter int unsigned MEM_AW = TDPA_MEM_AW
)
(
  input wire logic                    core_clk,
  input wire logic                    rst_n,
  input wire logic                    scl_in,
  input wire logic                    sda_oe_n,
  input wire logic                    supply_ok,
  input wire logic                    rd_req,
  input wire logic                    rd_tgt,
  input wire logic [TDPA_LINK_AW-1:0] rd_addr,
  input wire logic                    wr_valid,
  input wire logic                    wr_ready,
  input wire logic                    wr_tgt,
  input wire logic [TDPA_LINK_AW-1:0] wr_addr,
  input wire logic [7:0]              wr_data
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Fetch requests are single pulses, one per acknowledge of a read.
  property p_rd_pulse;
    rd_req |=> !rd_req;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("rd_req held two cycles");

  // Memory fetch addresses never carry bits beyond the array.
  property p_rd_mask;
    rd_req && !rd_tgt |-> (rd_addr >> MEM_AW) == 16'h0000;
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("read address beyond array");

  // Memory write addresses are masked the same way.
  property p_wr_mask;
    wr_valid && !wr_tgt |-> (wr_addr >> MEM_AW) == 16'h0000;
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("write address beyond array");

  // Register fetches stay inside the legal range.
  property p_rd_reg;
    rd_req && rd_tgt |-> rd_addr <= {8'h00, TDPA_REG_MAX};
  endproperty
  a_rd_reg: assert property (p_rd_reg) else $error("register read out of range");

  // An illegal register address never reaches a write.
  property p_wr_reg;
    wr_valid && wr_tgt |-> wr_addr <= {8'h00, TDPA_REG_MAX};
  endproperty
  a_wr_reg: assert property (p_wr_reg) else $error("register write out of range");

  // A stalled write command holds all of its fields.
  property p_wr_hold;
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data) && $stable(wr_tgt);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write command changed while stalled");

  // A driven low bit or acknowledge lasts at least nine core clocks.
  property p_drive_hold;
    $fell(sda_oe_n) |=> !sda_oe_n [*8];
  endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("SDA drive too short");

  // SDA never moves while SCL is high, which would fake Start or Stop.
  property p_scl_low;
    $changed(sda_oe_n) |-> !scl_in;
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("SDA moved with SCL high");

  // Supply loss takes the slave off the link.
  property p_supply;
    !supply_ok [*4] |=> sda_oe_n && !rd_req;
  endproperty
  a_supply: assert property (p_supply) else $error("link active during supply loss");
endmodule

bind tdpa_slave tdpa_slave_sva #(.MEM_AW(MEM_AW)) u_sva (.core_clk(core_clk), .rst_n(rst_n),
  .scl_in(scl_in), .sda_oe_n(sda_oe_n), .supply_ok(supply_ok), .rd_req(rd_req), .rd_tgt(rd_tgt),
  .rd_addr(rd_addr), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_tgt(wr_tgt), .wr_addr(wr_addr),
  .wr_data(wr_data));

`default_nettype wire

// File: verification/tb.sv
/*
  Self-checking bench for the two-wire slave with a small storage model.
  Assumes the master model and checker files are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  import tdpa_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n, supply_ok, wr_ready, rd_valid;
  logic [1:0]  dev_sel;
  logic [7:0]  rd_data;
  logic        scl, pull_n, sda_out, sda_oe_n, rd_req, rd_tgt, wr_valid, wr_tgt;
  logic [15:0] rd_addr, wr_addr;
  logic [7:0]  wr_data;
  logic [24:0] wq[$];
  int          n_errors = 0;
  int          num_checks = 0;
  wire         sda_w = pull_n & (sda_oe_n | sda_out);

  // 250 MHz core clock.
  always #2 core_clk = ~core_clk;

  tdpa_master_model m (.core_clk(core_clk), .sda(sda_w), .scl(scl), .pull_n(pull_n));

  // Smallest density keeps the wrap point near.
  tdpa_slave #(.MEM_AW(9)) dut (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .dev_sel(dev_sel), .supply_ok(supply_ok),
    .rd_req(rd_req), .rd_tgt(rd_tgt), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_tgt(wr_tgt), .wr_addr(wr_addr), .wr_data(wr_data));

  // Storage content is a pattern of the address, distinct per target.
  function automatic logic [7:0] pat(input logic t, input logic [15:0] a);
    return a[7:0] ^ (t ? 8'ha5 : 8'h5a);
  endfunction

  // Storage answers a fetch one cycle later; idle data keeps toggling.
  always @(negedge core_clk)
  begin
    rd_valid <= rd_req;
    rd_data <= rd_req ? pat(rd_tgt, rd_addr) : ~rd_data;
  end

  // Accepted write commands are queued for comparison.
  always @(posedge core_clk)
    if (wr_valid && wr_ready)
      wq.push_back({wr_tgt, wr_addr, wr_data});

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [24:0] seen, input logic [24:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Start plus slave byte, with the answer expected.
  task automatic begin_op(input logic [7:0] sa, input logic en);
    logic nk;
    m.start_c();
    m.wr_byte(sa, nk);
    check("slave ack", {24'h0, nk}, {24'h0, en});
  endtask

  task automatic send(input logic [7:0] b, input logic en);
    logic nk;
    m.wr_byte(b, nk);
    check("byte ack", {24'h0, nk}, {24'h0, en});
  endtask

  task automatic get(input logic nk, input logic [7:0] e);
    logic [7:0] d;
    m.rd_byte(nk, d);
    check("read byte", {17'h0, d}, {17'h0, e});
  endtask

  // Bounded wait for the next write command; an empty queue mismatches.
  task automatic expect_wr(input logic [24:0] e);
    for (int i = 0; i < 64 && wq.size() == 0; i++)
      @(negedge core_clk);
    check("write cmd", (wq.size() != 0) ? wq.pop_front() : 25'h1ffffff, e);
  endtask

  task automatic t_mem_write();
    begin_op(8'ha4, 1'b0);
    send(8'hff, 1'b0);
    send(8'hff, 1'b0);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    m.stop_c();
    expect_wr({1'b0, 16'h01ff, 8'h11});
    expect_wr({1'b0, 16'h0000, 8'h22});
  endtask

  task automatic t_mem_read();
    begin_op(8'ha5, 1'b0);
    get(1'b0, pat(1'b0, 16'h0001));
    get(1'b1, pat(1'b0, 16'h0002));
    m.stop_c();
  endtask

  // Register writes step and wrap; memory pointer holds.
  task automatic t_reg();
    begin_op(8'hd4, 1'b0);
    send(8'h17, 1'b0);
    send(8'h33, 1'b0);
    send(8'h44, 1'b0);
    send(8'h55, 1'b0);
    m.stop_c();
    expect_wr({1'b1, 16'h0017, 8'h33});
    expect_wr({1'b1, 16'h0018, 8'h44});
    expect_wr({1'b1, 16'h0000, 8'h55});
    begin_op(8'hd5, 1'b0);
    get(1'b1, pat(1'b1, 16'h0001));
    m.stop_c();
    begin_op(8'ha5, 1'b0);
    get(1'b1, pat(1'b0, 16'h0003));
    m.stop_c();
  endtask

  task automatic t_reg_bad();
    begin_op(8'hd4, 1'b0);
    send(8'h19, 1'b1);
    send(8'h66, 1'b1);
    m.stop_c();
    repeat (20) @(negedge core_clk);
    check("write count", wq.size(), 25'h0);
  endtask

  // Address load, a cut data byte, then a repeated Start into a read.
  task automatic t_selective();
    logic r;
    begin_op(8'ha4, 1'b0);
    send(8'h00, 1'b0);
    send(8'h40, 1'b0);
    for (int i = 0; i < 4; i++)
      m.bit_io(1'b0, r);
    begin_op(8'ha5, 1'b0);
    get(1'b1, pat(1'b0, 16'h0040));
    m.stop_c();
    check("write count", wq.size(), 25'h0);
  endtask

  task automatic t_refused();
    logic [7:0] bad[2] = '{8'hb4, 8'ha0};
    foreach (bad[i])
    begin
      begin_op(bad[i], 1'b1);
      m.stop_c();
    end
  endtask

  // Consumer stalls: sixteen bytes fit, the next is refused.
  task automatic t_fifo_full();
    @(negedge core_clk);
    wr_ready = 1'b0;
    begin_op(8'ha4, 1'b0);
    send(8'h00, 1'b0);
    send(8'h00, 1'b0);
    for (int i = 0; i < 16; i++)
      send(8'(i), 1'b0);
    send(8'hee, 1'b1);
    m.stop_c();
    wr_ready = 1'b1;
    for (int i = 0; i < 16; i++)
      expect_wr({1'b0, 16'(i), 8'(i)});
  endtask

  // Supply loss clears the memory pointer.
  task automatic t_supply();
    @(negedge core_clk);
    supply_ok = 1'b0;
    repeat (8) @(negedge core_clk);
    supply_ok = 1'b1;
    repeat (8) @(negedge core_clk);
    begin_op(8'ha5, 1'b0);
    get(1'b1, pat(1'b0, 16'h0000));
    m.stop_c();
  endtask

  // Hang guard.
  initial
  begin
    repeat (90000) @(posedge core_clk);
    n_errors++;
    summarize();
  end

  initial
  begin
    rst_n = 1'b0;
    supply_ok = 1'b1;
    dev_sel = 2'b10;
    wr_ready = 1'b1;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge core_clk);
    t_mem_write();
    t_mem_read();
    t_reg();
    t_reg_bad();
    t_selective();
    t_refused();
    t_fifo_full();
    t_supply();
    summarize();
  end
endmodule

`default_nettype wire
